// *** logic/asp_pkg.sv ***
// Purpose: Shared constants and types for the converter serial port
// Assumes: core clock is the oscillator input, 25 MHz
// Notes:   Counts are in oscillator cycles
`default_nettype none

package asp_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam int ASP_WORD_W = 24;
  localparam int ASP_NUM_REGS = 5;
  localparam logic [2:0] ASP_IDX_RESULT = 3'h0;
  localparam logic [2:0] ASP_IDX_CTRL = 3'h1;
  localparam logic [2:0] ASP_IDX_ZERO = 3'h2;
  localparam logic [2:0] ASP_IDX_POS = 3'h3;
  localparam logic [2:0] ASP_IDX_NEG = 3'h4;
  localparam logic [1:0] ASP_SEL_RESULT = 2'h0;
  localparam logic [1:0] ASP_SEL_CTRL = 2'h1;
  localparam logic [1:0] ASP_SEL_ZERO = 2'h2;
  localparam logic [1:0] ASP_SEL_SPAN = 2'h3;
  localparam logic [1:0] ASP_BYTE_NONE = 2'h3;

  // --------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------
  localparam int ASP_CTRL_BIDIR_BIT = 0;
  localparam int ASP_CTRL_LSB_FIRST_BIT = 1;
  localparam int ASP_CTRL_ASCEND_BIT = 2;
  localparam logic [23:0] ASP_CTRL_RST = 24'h000000;
  localparam logic [23:0] ASP_CAL_RST = 24'h000000;

  // --------------------------------------------------------------
  // Self clock timing
  // --------------------------------------------------------------
  localparam int ASP_SC_DIV = 8;
  localparam logic [4:0] ASP_SC_HALF_M1 = 5'(ASP_SC_DIV / 2 - 1);
  localparam int ASP_SC_LEAD_CYC = 29;
  localparam logic [4:0] ASP_SC_LEAD_LOAD = 5'(ASP_SC_LEAD_CYC - 2);
  localparam int ASP_SC_STALL_CYC = 28;
  localparam logic [4:0] ASP_SC_STALL_LOAD = 5'(ASP_SC_STALL_CYC - 1);
  localparam logic [3:0] ASP_SC_LAST_TOG = 4'hE;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ASP_SC_IDLE = 2'h0,
    ASP_SC_LEAD = 2'h1,
    ASP_SC_RUN = 2'h3,
    ASP_SC_STALL = 2'h2
  } asp_sc_e;

  typedef enum logic {
    ASP_SP_INSTR = 1'h0,
    ASP_SP_DATA = 1'h1
  } asp_sp_e;

  typedef struct packed {
    logic write;
    logic [1:0] count;
    logic full_scale_select;
    logic [1:0] reg_sel;
    logic [1:0] byte_sel;
  } asp_instr_s;

  typedef struct packed {
    logic mode;
    logic cs_n;
    logic sclk;
    logic sdio;
  } asp_pins_s;

endpackage : asp_pkg

`default_nettype wire

// *** logic/asp_serial_port.sv ***
// What this block does
// - Two-line mode on the data pin, or three-line with a separate out pin
// - Byte organized; each register byte addressed; one to four bytes a cycle
// - Bit order selectable; byte index ascends or descends from any start
// - Five 24-bit registers; result read only, the other four read/write
// - Mode pin low: host supplies shift clock up to 5 MHz
// - Mode pin high: device drives shift clock at oscillator/8, stalls high
// - Self clock: first transition 29 cycles after select is sampled
// - Self clock: eight clock cycles, then 28 cycle high stall, repeating
// - External clock: deselect freezes the port; resumes on reselect
// - External clock: outputs float one cycle after deselect is sampled
// - Self clock: a started byte always completes despite deselect
// - Self clock: deselected after a byte keeps clock stalled high
// - Interrupted multi-byte transfer continues with remaining bytes
// - Self clock read: outputs held to last bit; stall deselect one cycle
// - Two-line mode: serial out pin stays high impedance
// - Writes always enter on data pin; control bit picks read pin
// - Deselected outside a running self clock byte: both data outputs float; cycle suspended
// - Ready flag low on new result, high after complete result read
// - Each cycle: instruction byte, data bytes, then wait for instruction
// - Instruction bit 7 direction, bits 6..5 byte count minus one
// - Bits 3..2 register, 1..0 start byte, bit 4 picks span register
// - Data captured on rising shift clock edge
//
// Purpose: Serial register port of a sigma-delta converter
// Assumes: core clock is the oscillator input; pins are asynchronous
// Notes:   Conversion results arrive through an 8-word FIFO
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
module asp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // asp_fifo

// ----------------------------------------------------------------
// Serial port top
// ----------------------------------------------------------------
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Clock source strap and select
  input wire logic clock_source_i,
  input wire logic device_select_n_i,
  // Shift clock pin
  input wire logic shift_clock_i,
  output logic shift_clock_o,
  output logic shift_clock_oe_o,
  // Bidirectional data pin
  input wire logic serial_io_i,
  output logic serial_io_o,
  output logic serial_io_oe_o,
  // Serial out pin
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  // Ready flag
  output logic result_ready_n_o,
  // Conversion results from the converter core
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  input wire logic [ASP_WORD_W-1:0] conv_data_i,
  // Register contents to the converter core
  output logic [ASP_WORD_W-1:0] setup_control_o,
  output logic [ASP_WORD_W-1:0] zero_point_calibration_o,
  output logic [ASP_WORD_W-1:0] positive_span_calibration_o,
  output logic [ASP_WORD_W-1:0] negative_span_calibration_o
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [2:0] reg_index(input asp_instr_s ins);
    case (ins.reg_sel)
      ASP_SEL_RESULT: reg_index = ASP_IDX_RESULT;
      ASP_SEL_CTRL: reg_index = ASP_IDX_CTRL;
      ASP_SEL_ZERO: reg_index = ASP_IDX_ZERO;
      default: reg_index = ins.full_scale_select ? ASP_IDX_NEG : ASP_IDX_POS;
    endcase
  endfunction

  function automatic logic [7:0] get_byte(input logic [23:0] w,
                                          input logic [1:0] idx);
    case (idx)
      2'h0: get_byte = w[7:0];
      2'h1: get_byte = w[15:8];
      2'h2: get_byte = w[23:16];
      default: get_byte = 8'h00;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  asp_pins_s sync1_reg;
  asp_pins_s sync2_reg;
  logic sclk_s3_reg;
  logic self_mode;
  logic cs_act;
  logic ext_rise;
  logic ext_fall;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= '{mode: 1'b0, cs_n: 1'b1, sclk: 1'b1, sdio: 1'b0};
      sync2_reg <= '{mode: 1'b0, cs_n: 1'b1, sclk: 1'b1, sdio: 1'b0};
      sclk_s3_reg <= 1'b1;
    end else begin
      sync1_reg <= '{mode: clock_source_i, cs_n: device_select_n_i,
                     sclk: shift_clock_i, sdio: serial_io_i};
      sync2_reg <= sync1_reg;
      sclk_s3_reg <= sync2_reg.sclk;
    end
  end

  assign self_mode = sync2_reg.mode;
  assign cs_act = !sync2_reg.cs_n;
  // Edges count only while selected, so deselect freezes the port
  assign ext_rise = !self_mode && cs_act && sync2_reg.sclk
                    && !sclk_s3_reg;
  assign ext_fall = !self_mode && cs_act && !sync2_reg.sclk
                    && sclk_s3_reg;

  // --------------------------------------------------------------
  // Self clock generator
  // --------------------------------------------------------------
  asp_sc_e sc_state_reg;
  logic [4:0] sc_cnt_reg;
  logic [3:0] sc_tog_reg;
  logic sclk_reg;
  logic sc_rise_reg;
  logic sc_fall_reg;
  logic sc_run;
  logic sc_stall;

  assign sc_run = (sc_state_reg == ASP_SC_RUN);
  assign sc_stall = (sc_state_reg == ASP_SC_STALL);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sc_state_reg <= ASP_SC_IDLE;
      sc_cnt_reg <= 5'h00;
      sc_tog_reg <= 4'h0;
      sclk_reg <= 1'b1;
      sc_rise_reg <= 1'b0;
      sc_fall_reg <= 1'b0;
    end else begin
      sc_rise_reg <= 1'b0;
      sc_fall_reg <= 1'b0;
      case (sc_state_reg)
        ASP_SC_IDLE: begin
          if (self_mode && cs_act) begin
            sc_state_reg <= ASP_SC_LEAD;
            sc_cnt_reg <= ASP_SC_LEAD_LOAD;
          end
        end
        ASP_SC_LEAD: begin
          if (sc_cnt_reg == 5'h00) begin
            sc_state_reg <= ASP_SC_RUN;
            sclk_reg <= 1'b0;
            sc_fall_reg <= 1'b1;
            sc_cnt_reg <= ASP_SC_HALF_M1;
            sc_tog_reg <= 4'h0;
          end else begin
            sc_cnt_reg <= sc_cnt_reg - 5'h01;
          end
        end
        ASP_SC_RUN: begin
          // No select check here: a started byte always runs out
          if (sc_cnt_reg == 5'h00) begin
            sclk_reg <= !sclk_reg;
            sc_rise_reg <= !sclk_reg;
            sc_fall_reg <= sclk_reg;
            sc_cnt_reg <= ASP_SC_HALF_M1;
            sc_tog_reg <= sc_tog_reg + 4'h1;
            if (sc_tog_reg == ASP_SC_LAST_TOG) begin
              sc_state_reg <= ASP_SC_STALL;
              sc_cnt_reg <= ASP_SC_STALL_LOAD;
            end
          end else begin
            sc_cnt_reg <= sc_cnt_reg - 5'h01;
          end
        end
        ASP_SC_STALL: begin
          if (sc_cnt_reg != 5'h00) begin
            sc_cnt_reg <= sc_cnt_reg - 5'h01;
          end else if (self_mode && cs_act) begin
            sc_state_reg <= ASP_SC_RUN;
            sclk_reg <= 1'b0;
            sc_fall_reg <= 1'b1;
            sc_cnt_reg <= ASP_SC_HALF_M1;
            sc_tog_reg <= 4'h0;
          end else begin
            sc_state_reg <= ASP_SC_IDLE;
          end
        end
        default: sc_state_reg <= ASP_SC_IDLE;
      endcase
    end
  end

  assign shift_clock_o = sclk_reg;
  assign shift_clock_oe_o = self_mode;

  // --------------------------------------------------------------
  // Shift events
  // --------------------------------------------------------------
  logic rise_ev;
  logic fall_ev;

  assign rise_ev = self_mode ? sc_rise_reg : ext_rise;
  assign fall_ev = self_mode ? sc_fall_reg : ext_fall;

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [ASP_WORD_W-1:0] rf_reg [ASP_NUM_REGS];
  logic lsb_first;
  logic ascend;
  logic bidir;

  assign setup_control_o = rf_reg[ASP_IDX_CTRL];
  assign zero_point_calibration_o = rf_reg[ASP_IDX_ZERO];
  assign positive_span_calibration_o = rf_reg[ASP_IDX_POS];
  assign negative_span_calibration_o = rf_reg[ASP_IDX_NEG];
  assign lsb_first = rf_reg[ASP_IDX_CTRL][ASP_CTRL_LSB_FIRST_BIT];
  assign ascend = rf_reg[ASP_IDX_CTRL][ASP_CTRL_ASCEND_BIT];
  assign bidir = rf_reg[ASP_IDX_CTRL][ASP_CTRL_BIDIR_BIT];

  // --------------------------------------------------------------
  // Serial protocol engine
  // --------------------------------------------------------------
  asp_sp_e sp_state_reg;
  asp_instr_s instr_reg;
  asp_instr_s new_instr;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [1:0] step_idx;
  logic [1:0] left_reg;
  logic [7:0] tx_byte_reg;
  logic byte_done;
  logic reading;
  logic res_read_done;

  // Sampled data bit arrives at the rising edge
  assign shift_next = lsb_first ? {sync2_reg.sdio, shift_reg[7:1]}
                                : {shift_reg[6:0], sync2_reg.sdio};
  assign new_instr = asp_instr_s'(shift_next);
  assign byte_done = rise_ev && (bit_cnt_reg == 3'h7);
  assign step_idx = ascend ? byte_idx_reg + 2'h1
                           : byte_idx_reg - 2'h1;
  assign reading = (sp_state_reg == ASP_SP_DATA) && !instr_reg.write;
  assign res_read_done = byte_done && reading && (left_reg == 2'h0)
                         && (reg_index(instr_reg) == ASP_IDX_RESULT);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sp_state_reg <= ASP_SP_INSTR;
      instr_reg <= '0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 2'h0;
      left_reg <= 2'h0;
      tx_byte_reg <= 8'h00;
    end else if (rise_ev) begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        case (sp_state_reg)
          ASP_SP_INSTR: begin
            instr_reg <= new_instr;
            byte_idx_reg <= new_instr.byte_sel;
            left_reg <= new_instr.count;
            tx_byte_reg <= get_byte(rf_reg[reg_index(new_instr)],
                                    new_instr.byte_sel);
            sp_state_reg <= ASP_SP_DATA;
          end
          ASP_SP_DATA: begin
            byte_idx_reg <= step_idx;
            tx_byte_reg <= get_byte(rf_reg[reg_index(instr_reg)], step_idx);
            left_reg <= left_reg - 2'h1;
            if (left_reg == 2'h0) begin
              sp_state_reg <= ASP_SP_INSTR;
            end
          end
          default: sp_state_reg <= ASP_SP_INSTR;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Register writes and result loading
  // --------------------------------------------------------------
  logic fresh_reg;
  logic fifo_valid;
  logic fifo_take;
  logic [ASP_WORD_W-1:0] fifo_data;
  logic [2:0] wr_idx;

  assign wr_idx = reg_index(instr_reg);
  // Hold new results while the host is part way through a result read
  assign fifo_take = !fresh_reg && !(reading
                     && (wr_idx == ASP_IDX_RESULT));

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rf_reg[ASP_IDX_RESULT] <= 24'h000000;
      rf_reg[ASP_IDX_CTRL] <= ASP_CTRL_RST;
      rf_reg[ASP_IDX_ZERO] <= ASP_CAL_RST;
      rf_reg[ASP_IDX_POS] <= ASP_CAL_RST;
      rf_reg[ASP_IDX_NEG] <= ASP_CAL_RST;
    end else begin
      if (fifo_valid && fifo_take) begin
        rf_reg[ASP_IDX_RESULT] <= fifo_data;
      end
      if (byte_done && (sp_state_reg == ASP_SP_DATA) && instr_reg.write
          && (wr_idx != ASP_IDX_RESULT)
          && (byte_idx_reg != ASP_BYTE_NONE)) begin
        rf_reg[wr_idx][byte_idx_reg*8 +: 8] <= shift_next;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fresh_reg <= 1'b0;
    end else if (fifo_valid && fifo_take) begin
      fresh_reg <= 1'b1;
    end else if (res_read_done) begin
      fresh_reg <= 1'b0;
    end
  end

  assign result_ready_n_o = !fresh_reg;

  asp_fifo #(
    .WIDTH(ASP_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .in_data_i(conv_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_data)
  );

  // --------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------
  logic out_bit_reg;
  logic drive_reg;
  logic drive_next;

  // Self clock keeps driving through a running byte; external floats
  assign drive_next = reading && (self_mode ? (cs_act || sc_run)
                                            : cs_act);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_bit_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      if (fall_ev && reading) begin
        out_bit_reg <= lsb_first ? tx_byte_reg[bit_cnt_reg]
                                 : tx_byte_reg[3'h7 - bit_cnt_reg];
      end
    end
  end

  assign serial_io_o = out_bit_reg;
  assign serial_io_oe_o = drive_reg && bidir;
  assign serial_out_pin_o = out_bit_reg;
  assign serial_out_pin_oe_o = drive_reg && !bidir;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_byte_run;
    ##60 $rose(sc_stall);
  endsequence

  sequence s_stall_hold;
    ##27 sclk_reg ##1 (!sclk_reg || sc_state_reg == ASP_SC_IDLE);
  endsequence

  chk_serial_out_idle: assert property (
    bidir |-> !serial_out_pin_oe_o)
    else $error("serial out driven in two-line mode");

  chk_ext_deselect_off: assert property (
    !self_mode && !cs_act |=> !serial_io_oe_o && !serial_out_pin_oe_o)
    else $error("outputs driven after deselect in external mode");

  chk_self_lead_delay: assert property (
    sc_state_reg == ASP_SC_IDLE && self_mode && cs_act
    |-> ##1 sclk_reg ##28 !sclk_reg)
    else $error("first shift clock transition not at 29 cycles");

  chk_byte_length: assert property (
    $rose(sc_run) |-> s_byte_run)
    else $error("self clock byte not eight full cycles");

  chk_stall_length: assert property (
    $rose(sc_stall) |-> s_stall_hold)
    else $error("stall not 28 cycles high");

  chk_stall_high: assert property (
    sc_state_reg == ASP_SC_IDLE |-> sclk_reg)
    else $error("shift clock not parked high");

  chk_stall_off: assert property (
    self_mode && !cs_act && !sc_run |=> !serial_io_oe_o
    && !serial_out_pin_oe_o)
    else $error("outputs still driven one cycle after stall deselect");

  chk_ready_set: assert property (
    fifo_valid && fifo_take |=> !result_ready_n_o)
    else $error("ready flag not low after new result");

  chk_ready_clear: assert property (
    res_read_done && !(fifo_valid && fifo_take) |=> result_ready_n_o)
    else $error("ready flag not high after result read");

endmodule // asp_serial_port

`default_nettype wire

// *** dv/asp_host.sv ***
// Purpose: Host model on the far side of the serial port
// Assumes: external shift clock; pins move on falling core edges
// Notes:   Read data comes back on rx_i
`timescale 1ns/1ps
`default_nettype none
module asp_host (
  // Clock
  input wire logic core_clk_i,
  // Pins
  input wire logic rx_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sd_o,
  output logic sd_oe_o
);
  // Port shifts the instruction in its set bit order too
  logic lsb_ins;
  initial begin
    lsb_ins = 1'b0;
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  // ----
  // One byte, MSB first, optional break at bit 4
  // ----
  task automatic xb(input logic [7:0] t, input logic brk,
                    output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      sd_o = t[i];
      repeat (5) @(negedge core_clk_i);
      r[i] = rx_i;
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      if (brk && i == 4) begin
        cs_n_o = 1'b1;
        repeat (2) begin
          sclk_o = ~sclk_o;
          repeat (4) @(negedge core_clk_i);
        end
        cs_n_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
      end
    end
  endtask
  // ----
  // Instruction byte, then data bytes
  // ----
  task automatic frame(input logic [7:0] ins, input logic [31:0] w,
                       input logic brk, output logic [31:0] r);
    logic [7:0] b;
    logic [7:0] t;
    r = '0;
    for (int j = 0; j < 8; j++) begin
      t[j] = lsb_ins ? ins[7 - j] : ins[j];
    end
    cs_n_o = 1'b0;
    sd_oe_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    xb(t, 1'b0, b);
    sd_oe_o = ins[7];
    for (int k = 0; k <= int'(ins[6:5]); k++) begin
      xb(w[8*k+:8], brk, b);
      r[8*k+:8] = b;
    end
    repeat (4) @(negedge core_clk_i);
    cs_n_o = 1'b1;
    sd_oe_o = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask
endmodule // asp_host
`default_nettype wire

// *** dv/test_adc_serial_port_selfclock.sv ***
// Purpose: Self-checking bench for the converter serial port
// Assumes: host model drives the pins in external clock mode
// Notes:   Random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_port_selfclock;
  import asp_pkg::*;
  // ----
  // Signals
  // ----
  logic core_clk_i, sys_rst_i, strap, cvld, cs_n, hsc, hsd, hoe, rx;
  logic sc_o, sc_oe, sio_o, sio_oe, so_o, so_oe, rdy_n, crdy, bidir;
  logic sio_w;
  logic [23:0] cdat, ctl, zer, pos, neg;
  int seed = 11;
  int err_count = 0;
  int cmp_count = 0;
  int hc = 0;
  assign sio_w = sio_oe ? sio_o : (hoe ? hsd : ~sio_o);
  assign rx = bidir ? sio_w : (so_oe ? so_o : ~so_o);
  asp_serial_port u_asp_serial_port (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .clock_source_i(strap), .device_select_n_i(cs_n),
    .shift_clock_i(sc_oe ? sc_o : hsc), .shift_clock_o(sc_o),
    .shift_clock_oe_o(sc_oe), .serial_io_i(sio_w),
    .serial_io_o(sio_o), .serial_io_oe_o(sio_oe),
    .serial_out_pin_o(so_o), .serial_out_pin_oe_o(so_oe),
    .result_ready_n_o(rdy_n), .conv_valid_i(cvld),
    .conv_ready_o(crdy), .conv_data_i(cdat),
    .setup_control_o(ctl), .zero_point_calibration_o(zer),
    .positive_span_calibration_o(pos),
    .negative_span_calibration_o(neg));
  asp_host u_asp_host (.core_clk_i(core_clk_i), .rx_i(rx),
    .cs_n_o(cs_n), .sclk_o(hsc), .sd_o(hsd), .sd_oe_o(hoe));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] sw(input logic [23:0] v);
    return {8'h00, v[7:0], v[15:8], v[23:16]};
  endfunction
  function automatic logic [23:0] rv(input logic [23:0] x);
    logic [23:0] y;
    for (int j = 0; j < 24; j++) begin
      y[j] = x[23 - j];
    end
    return y;
  endfunction
  function automatic logic [7:0] ins(input logic w, input int s);
    return {w, 2'h2, s == 4, s > 3 ? 2'h3 : 2'(s), 2'h2};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(negedge core_clk_i) begin
    hc <= cs_n ? hc + 1 : 0;
    if (hc > 4) chk("float", 0, {sio_oe, so_oe});
    if (bidir) chk("out pin", 0, so_oe);
  end
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] r;
    logic [23:0] v;
    logic [23:0] q [$];
    int n;
    strap = 1'b0;
    cvld = 1'b0;
    cdat = '0;
    bidir = 1'b0;
    sys_rst_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    for (int s = 0; s < 5; s++) begin
      u_asp_host.frame(ins(0, s), 0, 0, r);
      chk("reset", 0, r);
    end
    for (int s = 2; s < 5; s++) begin
      v = 24'($random(seed));
      u_asp_host.frame(ins(1, s), sw(v), s == 3, r);
      chk("reg", v, s == 2 ? zer : s == 3 ? pos : neg);
      u_asp_host.frame(ins(0, s), 0, 0, r);
      chk("readback", sw(v), r);
    end
    u_asp_host.frame(ins(1, 0), sw(24'hA5A5A5), 0, r);
    u_asp_host.frame(ins(0, 0), 0, 0, r);
    chk("read only", 0, r);
    for (int i = 0; i < 12; i++) begin
      if (crdy === 1'b1) begin
        cdat = 24'($random(seed));
        cvld = 1'b1;
        q.push_back(cdat);
        @(negedge core_clk_i);
      end
    end
    cvld = 1'b0;
    chk("refused", 0, crdy);
    while (q.size() > 0) begin
      chk("flag", 0, rdy_n);
      u_asp_host.frame(ins(0, 0), 0, 0, r);
      chk("result", sw(q.pop_front()), r);
    end
    chk("flag", 1, rdy_n);
    u_asp_host.frame(8'h84, 32'h07, 0, r);
    chk("control", 24'h000007, ctl);
    bidir = 1'b1;
    u_asp_host.lsb_ins = 1'b1;
    v = 24'($random(seed));
    u_asp_host.frame(8'hC8, sw(rv(v)), 0, r);
    chk("lsb first", v, zer);
    u_asp_host.frame(8'h48, 0, 0, r);
    chk("two line", sw(rv(v)), r);
    bidir = 1'b0;
    strap = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk("clock drive", 1, sc_oe);
    u_asp_host.cs_n_o = 1'b0;
    n = 0;
    while (sc_o !== 1'b0 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("lead", 1, n > 29 && n < 33);
    u_asp_host.cs_n_o = 1'b1;
    n = 1;
    repeat (120) begin
      v[0] = sc_o;
      @(negedge core_clk_i);
      n += int'(v[0] & !sc_o);
    end
    chk("falls", 8, n);
    chk("park", 1, sc_o);
    finish_test();
  end
endmodule // test_adc_serial_port_selfclock
`default_nettype wire
